// ==== design/mmt_top.sv ====
/*
 * Timer array: five A-type channels (timer, event counter, one-shot,
 * PWM) and six B-type counters, with both start registers.
 * Assumes count_tick is a one-cycle pulse of the internal count source
 * and every pin input is synchronous to clock.
 */
// How it works
// - all channels halted after reset
// - B start bits at bits 7..5
// - timer read live, reload reads FFFF
// - event reload reads FFFF or 0000
// - one-shot stop reloads, output low, late flag
// - one-shot trigger waits for count source
// - entering one-shot from timer or event sets request flag
// - retrigger decrements once, then reloads
// - entering PWM from timer or event sets request flag
// - PWM stop drops high output, flags
// - channels 1,2,4 float under forced cutoff
// - measure edge and overflow both flag
// - overflow status clears by armed mode write
// - first measured edge raises no request
// - early overflow requests may occur
// - changed measure select may flag
// - width measurement runs on alternate levels
`include "mmt_regs.svh"

module mmt_top
	import mmt_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic count_tick,
	input wire logic start_first_wr,
	input wire logic start_second_wr,
	input wire logic [7:0] start_wdata,
	output logic [7:0] count_start_register_first,
	output logic [7:0] count_start_register_second,
	input wire logic [15:0] wdata,
	input wire logic [`MMT_A_NUM-1:0] a_mode_wr,
	input wire logic [`MMT_A_NUM-1:0] a_cnt_wr,
	input wire logic [`MMT_A_NUM-1:0] a_irq_clr,
	input wire logic [`MMT_A_NUM-1:0] up_down_select,
	input wire logic [`MMT_A_NUM-1:0] a_event_pin,
	input wire logic [`MMT_A_NUM-1:0] a_channel_trigger_pin,
	output logic [`MMT_A_NUM-1:0][15:0] a_channel_counter,
	output logic [`MMT_A_NUM-1:0] a_channel_output_pin,
	output logic [`MMT_A_NUM-1:0] a_channel_output_oe_n,
	output logic [`MMT_A_NUM-1:0] a_irq,
	input wire logic nmi_n,
	input wire logic forced_cutoff_high_bit,
	input wire logic forced_cutoff_low_bit,
	input wire logic [`MMT_B_NUM-1:0] b_mode_wr,
	input wire logic [`MMT_B_NUM-1:0] b_cnt_wr,
	input wire logic [`MMT_B_NUM-1:0] b_irq_clr,
	input wire logic [`MMT_B_NUM-1:0] b_pin,
	output logic [`MMT_B_NUM-1:0][15:0] b_channel_counter,
	output logic [`MMT_B_NUM-1:0] b_irq,
	output logic [`MMT_B_NUM-1:0] overflow_status_bit
);

	mmt_top_state_t s;
	mmt_top_state_t next_s;
	logic cutoff;
	mmt_wr_t b_wr [`MMT_B_NUM];

	always_comb begin
		mmt_a_state_t cur;
		mmt_a_state_t nx;
		logic run;
		logic ev_edge;
		logic trig_edge;
		mmt_a_mode_t new_mode;
		cur = '0;
		nx = '0;
		run = 1'b0;
		ev_edge = 1'b0;
		trig_edge = 1'b0;
		new_mode = mmt_a_mode_t'(wdata[`MMT_MODE_MSB:`MMT_MODE_LSB]);
		next_s = s;
		// B start bits in the upper field
		if (start_first_wr) begin
			next_s.a_start = start_wdata[`MMT_A_START_MSB:`MMT_A_START_LSB];
			next_s.b_start[`MMT_B_HALF-1:0] =
				start_wdata[`MMT_B_START_MSB:`MMT_B_START_LSB];
		end
		if (start_second_wr)
			next_s.b_start[`MMT_B_NUM-1:`MMT_B_HALF] =
				start_wdata[`MMT_B_START_MSB:`MMT_B_START_LSB];
		for (int i = 0; i < `MMT_A_NUM; i++) begin
			cur = s.a[i];
			nx = cur;
			run = s.a_start[i];
			ev_edge = a_event_pin[i] & ~cur.ev_q;
			trig_edge = a_channel_trigger_pin[i] & ~cur.trig_q;
			nx.start_q = run;
			nx.ev_q = a_event_pin[i];
			nx.trig_q = a_channel_trigger_pin[i];
			// clear first so that any set below wins
			if (a_irq_clr[i])
				nx.irq = 1'b0;
			if (cur.irq_dly) begin
				nx.irq = 1'b1;
				nx.irq_dly = 1'b0;
			end
			if (cur.rld) begin
				nx.cnt = cur.reload;
				nx.rld = 1'b0;
			end
			unique case (cur.mode)
				MMT_A_TIMER: begin
					if (run && count_tick && !cur.rld) begin
						nx.fresh = 1'b0;
						if (cur.cnt == `MMT_CNT_ZERO) begin
							nx.rld = 1'b1;
							nx.rld_up = 1'b0;
							nx.irq = 1'b1;
						end else begin
							nx.cnt = cur.cnt - `MMT_CNT_ONE;
						end
					end
				end
				MMT_A_EVENT: begin
					if (run && ev_edge && !cur.rld) begin
						nx.fresh = 1'b0;
						if (up_down_select[i] && cur.cnt == `MMT_CNT_MAX) begin
							nx.rld = 1'b1;
							nx.rld_up = 1'b1;
							nx.irq = 1'b1;
						end else if (!up_down_select[i] &&
						    cur.cnt == `MMT_CNT_ZERO) begin
							nx.rld = 1'b1;
							nx.rld_up = 1'b0;
							nx.irq = 1'b1;
						end else if (up_down_select[i]) begin
							nx.cnt = cur.cnt + `MMT_CNT_ONE;
						end else begin
							nx.cnt = cur.cnt - `MMT_CNT_ONE;
						end
					end
				end
				MMT_A_ONESHOT: begin
					nx.trig_pend = cur.trig_pend | trig_edge;
					if (!run && cur.start_q && cur.busy) begin
						// stop reloads, drops output, late flag
						nx.busy = 1'b0;
						nx.out = 1'b0;
						nx.cnt = cur.reload;
						nx.rld = 1'b0;
						nx.trig_pend = 1'b0;
						nx.irq_dly = 1'b1;
					end else if (run && count_tick) begin
						// triggers act on the count source
						if (cur.trig_pend) begin
							nx.trig_pend = trig_edge;
							nx.fresh = 1'b0;
							if (!cur.busy) begin
								nx.busy = 1'b1;
								nx.out = 1'b1;
							end else begin
								nx.cnt = cur.cnt - `MMT_CNT_ONE;
								nx.rld = 1'b1;
							end
						end else if (cur.busy && !cur.rld) begin
							if (cur.cnt == `MMT_CNT_ZERO) begin
								nx.busy = 1'b0;
								nx.out = 1'b0;
								nx.rld = 1'b1;
								nx.irq = 1'b1;
							end else begin
								nx.cnt = cur.cnt - `MMT_CNT_ONE;
							end
						end
					end
				end
				MMT_A_PWM: begin
					if (!run && cur.start_q) begin
						// stop; only a high output flags
						nx.busy = 1'b0;
						if (cur.out) begin
							nx.out = 1'b0;
							nx.irq = 1'b1;
						end
					end else if (run && !cur.start_q) begin
						nx.busy = 1'b1;
						nx.out = 1'b1;
						nx.fresh = 1'b0;
						nx.cnt = cur.reload;
					end else if (run && count_tick && cur.busy) begin
						// high phase lasts reload, low phase its complement
						if (cur.cnt == `MMT_CNT_ZERO) begin
							nx.out = ~cur.out;
							nx.cnt = cur.out ? ~cur.reload : cur.reload;
							nx.irq = 1'b1;
						end else begin
							nx.cnt = cur.cnt - `MMT_CNT_ONE;
						end
					end
				end
			endcase
			if (a_mode_wr[i]) begin
				nx.mode = new_mode;
				nx.busy = 1'b0;
				if ((new_mode == MMT_A_ONESHOT || new_mode == MMT_A_PWM) &&
				    (cur.mode == MMT_A_TIMER || cur.mode == MMT_A_EVENT))
					nx.irq = 1'b1;
			end
			if (a_cnt_wr[i]) begin
				nx.cnt = wdata;
				nx.reload = wdata;
				nx.fresh = 1'b1;
			end
			next_s.a[i] = nx;
		end
	end

	// reset leaves every start bit clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	// forced cutoff floats channels 1, 2 and 4
	assign cutoff = !nmi_n &&
		{forced_cutoff_high_bit, forced_cutoff_low_bit} == `MMT_CUTOFF_ON;
	assign a_channel_output_oe_n = cutoff ? `MMT_CUTOFF_MASK : '0;

	always_comb begin
		for (int i = 0; i < `MMT_A_NUM; i++) begin
			// reload reads FFFF, or 0000 after counting up; unstarted reads setting
			if (s.a[i].rld)
				a_channel_counter[i] = s.a[i].rld_up ?
					`MMT_CNT_ZERO : `MMT_CNT_MAX;
			else
				a_channel_counter[i] = s.a[i].fresh ?
					s.a[i].reload : s.a[i].cnt;
			a_channel_output_pin[i] = s.a[i].out;
			a_irq[i] = s.a[i].irq;
		end
	end

	assign count_start_register_first =
		{s.b_start[`MMT_B_HALF-1:0], s.a_start};
	assign count_start_register_second =
		{s.b_start[`MMT_B_NUM-1:`MMT_B_HALF], `MMT_START_PAD};

	for (genvar g = 0; g < `MMT_B_NUM; g++) begin : g_b
		assign b_wr[g] = '{mode_wr: b_mode_wr[g], cnt_wr: b_cnt_wr[g],
			irq_clr: b_irq_clr[g], data: wdata};
		mmt_b_chan u_chan (
			.clock(clock),
			.rstn(rstn),
			.ce(ce),
			.start(s.b_start[g]),
			.count_tick(count_tick),
			.pin(b_pin[g]),
			.wr(b_wr[g]),
			.counter(b_channel_counter[g]),
			.irq(b_irq[g]),
			.overflow_status_bit(overflow_status_bit[g])
		);
	end

	chk_reset_halted: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(rstn) |-> count_start_register_first == '0 &&
			count_start_register_second == '0
	) else $error("a channel runs right after reset");

	chk_b_start_bits: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && start_first_wr |=> count_start_register_first ==
			$past(start_wdata)
	) else $error("first start register mismatch");

	chk_timer_reload: assert property (
		@(posedge clock) disable iff (!rstn)
		s.a[0].mode == MMT_A_TIMER && s.a[0].rld |->
			a_channel_counter[0] == `MMT_CNT_MAX
	) else $error("timer reload cycle does not read all ones");

	chk_oneshot_stop: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && s.a[1].mode == MMT_A_ONESHOT && s.a[1].busy &&
		s.a[1].start_q && !s.a_start[1] && !a_mode_wr[1] && !a_cnt_wr[1]
		|=> (!a_channel_output_pin[1] and (ce |=> a_irq[1]))
	) else $error("one-shot stop did not drop output and flag");

	chk_oneshot_entry: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && a_mode_wr[1] &&
		wdata[`MMT_MODE_MSB:`MMT_MODE_LSB] == MMT_A_ONESHOT &&
		s.a[1].mode == MMT_A_TIMER |=> a_irq[1]
	) else $error("entering one-shot did not flag");

	chk_pwm_stop: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && s.a[2].mode == MMT_A_PWM && s.a[2].start_q &&
		!s.a_start[2] && s.a[2].out && !a_mode_wr[2]
		|=> !a_channel_output_pin[2] && a_irq[2]
	) else $error("PWM stop with high output misbehaved");

	chk_cutoff_float: assert property (
		@(posedge clock) disable iff (!rstn)
		!nmi_n && forced_cutoff_high_bit && forced_cutoff_low_bit |->
			a_channel_output_oe_n[1] && a_channel_output_oe_n[2] &&
			a_channel_output_oe_n[4] && !a_channel_output_oe_n[0]
	) else $error("forced cutoff did not float outputs");

endmodule : mmt_top

// ==== design/mmt_regs.svh ====
/*
 * Constants of the timer array: start register bit positions, mode
 * register field positions, count limits and guard times.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef MMT_REGS_SVH
`define MMT_REGS_SVH

`define MMT_A_NUM 5
`define MMT_B_NUM 6
`define MMT_B_HALF 3
`define MMT_A_START_MSB 4
`define MMT_A_START_LSB 0
`define MMT_B_START_MSB 7
`define MMT_B_START_LSB 5
`define MMT_START_PAD 5'h00
`define MMT_MODE_MSB 1
`define MMT_MODE_LSB 0
`define MMT_MSEL_MSB 3
`define MMT_MSEL_LSB 2
`define MMT_CNT_MAX 16'hffff
`define MMT_CNT_ZERO 16'h0000
`define MMT_CNT_ONE 16'h0001
`define MMT_CUTOFF_ON 2'h3
`define MMT_CUTOFF_MASK 5'h16
`define MMT_CLK_NS 10
`define MMT_TRIG_GUARD_NS 300
`define MMT_TRIG_GUARD_CYC (`MMT_TRIG_GUARD_NS / `MMT_CLK_NS)

`endif

// ==== design/mmt_pkg.sv ====
/*
 * Types of the timer array: channel modes and per-channel state.
 * Assumes the constants header is on the include path.
 */
`include "mmt_regs.svh"

package mmt_pkg;

	typedef enum logic [1:0] {
		MMT_A_TIMER = 2'b00,
		MMT_A_EVENT = 2'b01,
		MMT_A_ONESHOT = 2'b10,
		MMT_A_PWM = 2'b11
	} mmt_a_mode_t;

	typedef enum logic [1:0] {
		MMT_B_TIMER = 2'b00,
		MMT_B_EVENT = 2'b01,
		MMT_B_MEASURE = 2'b10
	} mmt_b_mode_t;

	typedef struct packed {
		mmt_a_mode_t mode;
		logic [15:0] cnt;
		logic [15:0] reload;
		logic fresh;
		logic rld;
		logic rld_up;
		logic out;
		logic busy;
		logic trig_pend;
		logic irq;
		logic irq_dly;
		logic start_q;
		logic ev_q;
		logic trig_q;
	} mmt_a_state_t;

	typedef struct packed {
		logic [`MMT_A_NUM-1:0] a_start;
		logic [`MMT_B_NUM-1:0] b_start;
		mmt_a_state_t [`MMT_A_NUM-1:0] a;
	} mmt_top_state_t;

	typedef struct packed {
		mmt_b_mode_t mode;
		logic [1:0] msel;
		logic [15:0] cnt;
		logic [15:0] reload;
		logic fresh;
		logic rld;
		logic ovf;
		logic ovf_armed;
		logic got_edge;
		logic irq;
		logic start_q;
		logic pin_q;
	} mmt_b_state_t;

	// one channel's software access, carried as one bundle
	typedef struct packed {
		logic mode_wr;
		logic cnt_wr;
		logic irq_clr;
		logic [15:0] data;
	} mmt_wr_t;

endpackage : mmt_pkg

// ==== design/mmt_b_chan.sv ====
/*
 * One B-type 16-bit counter: timer, event counter and pulse
 * period/width measurement.
 * Assumes count_tick is a one-cycle count-source pulse and pin is
 * synchronous to clock.
 */
`include "mmt_regs.svh"

module mmt_b_chan
	import mmt_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic start,
	input wire logic count_tick,
	input wire logic pin,
	input wire mmt_wr_t wr,
	output logic [15:0] counter,
	output logic irq,
	output logic overflow_status_bit
);

	mmt_b_state_t s;
	mmt_b_state_t next_s;
	logic rise;
	logic fall;
	logic vedge;
	logic [1:0] new_msel;

	assign rise = pin & ~s.pin_q;
	assign fall = ~pin & s.pin_q;
	assign new_msel = wr.data[`MMT_MSEL_MSB:`MMT_MSEL_LSB];

	always_comb begin
		unique case (s.msel)
			2'h0: vedge = fall;
			2'h1: vedge = rise;
			default: vedge = rise | fall;
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.start_q = start;
		next_s.pin_q = pin;
		if (wr.irq_clr)
			next_s.irq = 1'b0;
		if (s.rld) begin
			next_s.cnt = s.reload;
			next_s.rld = 1'b0;
		end
		if (start && !s.start_q)
			next_s.got_edge = 1'b0;
		if (wr.mode_wr) begin
			next_s.mode = mmt_b_mode_t'(wr.data[`MMT_MODE_MSB:`MMT_MODE_LSB]);
			next_s.msel = new_msel;
			if (s.ovf_armed) begin
				next_s.ovf = 1'b0;
				next_s.ovf_armed = 1'b0;
			end
			if (start && s.mode == MMT_B_MEASURE && new_msel != s.msel)
				next_s.irq = 1'b1;
		end
		if (wr.cnt_wr) begin
			next_s.cnt = wr.data;
			next_s.reload = wr.data;
			next_s.fresh = 1'b1;
		end
		unique case (s.mode)
			MMT_B_TIMER, MMT_B_EVENT: begin
				if (start && !s.rld && ((s.mode == MMT_B_TIMER) ?
				    count_tick : rise)) begin
					next_s.fresh = 1'b0;
					if (s.cnt == `MMT_CNT_ZERO) begin
						next_s.rld = 1'b1;
						next_s.irq = 1'b1;
					end else begin
						next_s.cnt = s.cnt - `MMT_CNT_ONE;
					end
				end
			end
			MMT_B_MEASURE: begin
				if (start && vedge) begin
					next_s.reload = s.cnt;
					next_s.cnt = `MMT_CNT_ZERO;
					next_s.got_edge = 1'b1;
					if (s.got_edge)
						next_s.irq = 1'b1;
				end else if (start && count_tick) begin
					if (s.cnt == `MMT_CNT_MAX) begin
						next_s.ovf = 1'b1;
						next_s.ovf_armed = 1'b0;
						next_s.irq = 1'b1;
					end else if (s.ovf) begin
						next_s.ovf_armed = 1'b1;
					end
					next_s.cnt = s.cnt + `MMT_CNT_ONE;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign counter = s.rld ? `MMT_CNT_MAX :
		((s.mode == MMT_B_MEASURE || s.fresh) ? s.reload : s.cnt);
	assign irq = s.irq;
	assign overflow_status_bit = s.ovf;

	chk_ovf_sets_irq: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && start && s.mode == MMT_B_MEASURE && count_tick && !vedge &&
		s.cnt == `MMT_CNT_MAX |=> overflow_status_bit && irq
	) else $error("overflow did not set status and request");

	chk_ovf_held: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && s.ovf && !s.ovf_armed |=> overflow_status_bit
	) else $error("overflow status cleared before armed");

	chk_first_quiet: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && start && s.mode == MMT_B_MEASURE && vedge && !s.got_edge &&
		!s.irq && !wr.mode_wr |=> !irq
	) else $error("first measured edge raised a request");

	chk_msel_same: assert property (
		@(posedge clock) disable iff (!rstn)
		ce && start && wr.mode_wr && s.mode == MMT_B_MEASURE &&
		new_msel == s.msel && !s.irq && !vedge && !count_tick |=> !irq
	) else $error("rewriting the same select raised a request");

endmodule : mmt_b_chan

// ==== test/mmt_pin_model.sv ====
/*
 * Far-side model of the timer array: event, trigger and measured pulse
 * pins, driven on request from the bench.
 * Assumes the bench calls its tasks from one process and spaces calls.
 */
`include "mmt_regs.svh"

module mmt_pin_model (
	input wire logic clock,
	output logic [`MMT_A_NUM-1:0] a_event_pin,
	output logic [`MMT_A_NUM-1:0] a_channel_trigger_pin,
	output logic [`MMT_B_NUM-1:0] b_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		a_event_pin = '0;
		a_channel_trigger_pin = '0;
		b_pin = '0;
	end

	// callers keep triggers far from zero
	task automatic trig(input int ch);
		@(posedge clock);
		#1 a_channel_trigger_pin[ch] = 1'b1;
		repeat (2) @(posedge clock);
		#1 a_channel_trigger_pin[ch] = 1'b0;
	endtask

	// both edges spaced so the edge detector sees each one
	task automatic pulse(input int ch);
		@(posedge clock);
		#1 b_pin[ch] = 1'b1;
		repeat (2) @(posedge clock);
		#1 b_pin[ch] = 1'b0;
		repeat (2) @(posedge clock);
		// callers resume off the edge, never in its time step
		#1;
	endtask

	// one-cycle event; returns just after the edge that counts it
	task automatic ev(input int ch);
		@(posedge clock);
		#1 a_event_pin[ch] = 1'b1;
		@(posedge clock);
		#1 a_event_pin[ch] = 1'b0;
	endtask
endmodule // mmt_pin_model

// ==== test/multi_mode_timer_array_test.sv ====
/*
 * Self-checking bench of the timer array: start registers, timer walk,
 * one-shot and PWM entry and stop, forced cutoff, pulse measurement.
 * Assumes the pin model drives the event, trigger and measured pulse pins of the array; the bench drives nmi_n.
 */
`include "mmt_regs.svh"

module multi_mode_timer_array_test;
	import mmt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 0, rstn = 0, ce = 1, count_tick = 0;
	logic start_first_wr = 0, start_second_wr = 0;
	logic [7:0] start_wdata = '0;
	logic [7:0] count_start_register_first, count_start_register_second;
	logic [15:0] wdata = '0;
	logic [`MMT_A_NUM-1:0] a_mode_wr = '0, a_cnt_wr = '0, a_irq_clr = '0;
	logic [`MMT_A_NUM-1:0] up_down_select = '0;
	logic [`MMT_A_NUM-1:0] a_event_pin, a_channel_trigger_pin;
	logic [`MMT_A_NUM-1:0][15:0] a_channel_counter;
	logic [`MMT_A_NUM-1:0] a_channel_output_pin, a_channel_output_oe_n;
	logic [`MMT_A_NUM-1:0] a_irq;
	logic nmi_n = 1, forced_cutoff_high_bit = 0, forced_cutoff_low_bit = 0;
	logic [`MMT_B_NUM-1:0] b_mode_wr = '0, b_cnt_wr = '0, b_irq_clr = '0;
	logic [`MMT_B_NUM-1:0] b_pin, b_irq, overflow_status_bit;
	logic [`MMT_B_NUM-1:0][15:0] b_channel_counter;
	int num_errors = 0;
	int tests_run = 0;

	mmt_top DUT (.clock, .rstn, .ce, .count_tick, .start_first_wr,
		.start_second_wr, .start_wdata, .count_start_register_first,
		.count_start_register_second, .wdata, .a_mode_wr, .a_cnt_wr,
		.a_irq_clr, .up_down_select, .a_event_pin, .a_channel_trigger_pin,
		.a_channel_counter, .a_channel_output_pin, .a_channel_output_oe_n,
		.a_irq, .nmi_n, .forced_cutoff_high_bit, .forced_cutoff_low_bit,
		.b_mode_wr, .b_cnt_wr, .b_irq_clr, .b_pin, .b_channel_counter,
		.b_irq, .overflow_status_bit);

	mmt_pin_model P (.clock, .a_event_pin, .a_channel_trigger_pin, .b_pin);

	initial begin
		forever #5 clock = ~clock;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic check(input string name, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// strobes rise one edge after entry so no signal is set twice a step
	task automatic wr_start(input logic second, input logic [7:0] d);
		cyc(1);
		start_wdata = d;
		start_first_wr = !second;
		start_second_wr = second;
		cyc(1);
		start_first_wr = 0;
		start_second_wr = 0;
	endtask

	// program only while stopped
	// kind 0 mode, 1 counter, 2 flag clear
	task automatic wr_a(input int ch, kind, input logic [15:0] d);
		cyc(1);
		wdata = d;
		a_mode_wr[ch] = (kind == 0);
		a_cnt_wr[ch] = (kind == 1);
		a_irq_clr[ch] = (kind == 2);
		cyc(1);
		a_mode_wr = '0;
		a_cnt_wr = '0;
		a_irq_clr = '0;
	endtask

	task automatic wr_b(input int ch, kind, input logic [15:0] d);
		cyc(1);
		wdata = d;
		b_mode_wr[ch] = (kind == 0);
		b_cnt_wr[ch] = (kind == 1);
		b_irq_clr[ch] = (kind == 2);
		cyc(1);
		b_mode_wr = '0;
		b_cnt_wr = '0;
		b_irq_clr = '0;
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			cyc(1);
			count_tick = 1;
			cyc(1);
			count_tick = 0;
		end
	endtask

	initial begin
		#200us;
		num_errors++;
		finish_test();
	end

	initial begin
		cyc(5);
		rstn = 1;
		check("start first", count_start_register_first, 16'h0000);
		check("a flags", a_irq, 16'h0000);
		wr_start(0, 8'he0);
		check("start first", count_start_register_first, 16'h00e0);
		wr_start(1, 8'hff);
		check("start 2nd", count_start_register_second, 16'h00e0);
		wr_start(0, 8'h00);
		wr_start(1, 8'h00);
		check("start 2nd", count_start_register_second, 16'h0000);
		// timer walk on channel A0
		wr_a(0, 0, 16'h0000);
		wr_a(0, 1, 16'h0002);
		wr_start(0, 8'h01);
		check("timer set", a_channel_counter[0], 16'h0002);
		tick(1);
		check("timer live", a_channel_counter[0], 16'h0001);
		tick(1);
		check("timer live", a_channel_counter[0], 16'h0000);
		tick(1);
		check("timer reload", a_channel_counter[0], 16'hffff);
		check("timer flag", a_irq[0], 16'h0001);
		cyc(1);
		check("reloaded", a_channel_counter[0], 16'h0002);
		wr_start(0, 8'h00);
		// one-shot on A1, retriggered, then stopped mid-count
		wr_a(1, 0, 16'h0002);
		check("oneshot entry", a_irq[1], 16'h0001);
		wr_a(1, 2, 16'h0000);
		wr_a(1, 1, 16'h0003);
		wr_start(0, 8'h02);
		P.trig(1);
		check("os wait", a_channel_output_pin[1], 16'h0000);
		tick(1);
		check("os high", a_channel_output_pin[1], 16'h0001);
		tick(1);
		P.trig(1);
		tick(1);
		cyc(1);
		check("retrigger", a_channel_counter[1], 16'h0003);
		check("retrig out", a_channel_output_pin[1], 16'h0001);
		tick(1);
		wr_start(0, 8'h00);
		// the stop acts one edge after the start bit drops
		cyc(1);
		check("stop out", a_channel_output_pin[1], 16'h0000);
		check("stop reload", a_channel_counter[1], 16'h0003);
		check("stop flag late", a_irq[1], 16'h0000);
		cyc(1);
		check("stop flag", a_irq[1], 16'h0001);
		// PWM on A2: stopped while low, then while high
		wr_a(2, 0, 16'h0003);
		check("pwm entry", a_irq[2], 16'h0001);
		wr_a(2, 2, 16'h0000);
		wr_a(2, 1, 16'h0004);
		wr_start(0, 8'h04);
		tick(5);
		check("pwm low phase", a_channel_output_pin[2], 16'h0000);
		wr_a(2, 2, 16'h0000);
		wr_start(0, 8'h00);
		cyc(2);
		check("pwm low out", a_channel_output_pin[2], 16'h0000);
		check("pwm low flag", a_irq[2], 16'h0000);
		wr_start(0, 8'h04);
		wr_start(0, 8'h00);
		cyc(1);
		check("pwm high out", a_channel_output_pin[2], 16'h0000);
		check("pwm high flag", a_irq[2], 16'h0001);
		// forced cutoff: only both bits with nmi low float 1, 2, 4
		nmi_n = 0;
		forced_cutoff_high_bit = 1;
		cyc(1);
		check("cutoff half", a_channel_output_oe_n, 16'h0000);
		forced_cutoff_low_bit = 1;
		cyc(1);
		check("cutoff on", a_channel_output_oe_n, 16'h0016);
		nmi_n = 1;
		cyc(1);
		check("cutoff off", a_channel_output_oe_n, 16'h0000);
		// event counting on A3: up past ffff, then down past 0000
		up_down_select[3] = 1;
		wr_a(3, 0, 16'h0001);
		wr_a(3, 1, 16'hfffe);
		wr_start(0, 8'h08);
		P.ev(3);
		check("event up", a_channel_counter[3], 16'hffff);
		P.ev(3);
		check("event ovf", a_channel_counter[3], 16'h0000);
		check("event flag", a_irq[3], 16'h0001);
		wr_start(0, 8'h00);
		up_down_select[3] = 0;
		wr_a(3, 1, 16'h0000);
		wr_start(0, 8'h08);
		P.ev(3);
		check("event udf", a_channel_counter[3], 16'hffff);
		wr_start(0, 8'h00);
		// rising-to-rising period measurement on B0
		wr_b(0, 0, 16'h0006);
		wr_b(0, 2, 16'h0000);
		wr_start(0, 8'h20);
		tick(2);
		P.pulse(0);
		check("first edge quiet", b_irq[0], 16'h0000);
		tick(3);
		P.pulse(0);
		check("edge flag", b_irq[0], 16'h0001);
		check("period", b_channel_counter[0], 16'h0003);
		wr_b(0, 2, 16'h0000);
		wr_b(0, 0, 16'h0006);
		cyc(2);
		check("same select quiet", b_irq[0], 16'h0000);
		// width measurement on B1 flags on the falling edge too
		wr_b(1, 0, 16'h000a);
		wr_start(0, 8'h40);
		P.pulse(1);
		check("width flag", b_irq[1], 16'h0001);
		// timer on B2, one count source swallowed by ce low
		wr_b(2, 1, 16'h0001);
		wr_start(0, 8'h80);
		tick(1);
		ce = 0;
		tick(1);
		ce = 1;
		check("frozen", b_channel_counter[2], 16'h0000);
		tick(1);
		check("b reload", b_channel_counter[2], 16'hffff);
		check("b flag", b_irq[2], 16'h0001);
		wr_start(0, 8'h00);
		// overflow on B3, started from the second start register
		wr_b(3, 0, 16'h0006);
		wr_b(3, 1, 16'hfffe);
		wr_start(1, 8'h20);
		tick(2);
		check("ovf status", overflow_status_bit[3], 16'h0001);
		check("ovf flag", b_irq[3], 16'h0001);
		wr_b(3, 0, 16'h0006);
		check("ovf unarmed", overflow_status_bit[3], 16'h0001);
		tick(1);
		wr_b(3, 0, 16'h0006);
		check("ovf cleared", overflow_status_bit[3], 16'h0000);
		wr_start(1, 8'h00);
		finish_test();
	end
endmodule // multi_mode_timer_array_test
